// ===== hw/pm_reg_bank.sv
/*
 * Power-management register bank: control with sleep trigger, sticky event
 * status with enables, live status, embedded-controller query value and an
 * interrupt that can be routed to any of the shared lines.
 * Assumes a one-cycle register port master on mclk_i and asynchronous
 * event pins that are synchronised here.
 */
// Function
// - Each register sits at a fixed address so software reaches it directly.
// - A write-only bit acts once each time a one is written to it; a zero does nothing.
// - Enable and control bits read back what software last wrote.
// - Plain status bits read the live value of their signal with no latching.
// - A sticky bit is set by the high level of its source, not an edge.
// - A sticky bit stays set until software writes a one to it.
// - The sleep trigger lives at bit 13 of the power management control register.
// - Enabled events raise the system control interrupt, routable to any shared line.
// - On a query command the controller returns a query value naming the event.
// - Docking logic raises an event on dock detect and on an undock request.
// - Software writes the sleep type in the same write as the trigger; hardware enters that state.
`timescale 1ns/1ps
`default_nettype none

module pm_reg_bank #(
    parameter int N_LIVE = 8
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [pm_regs_pkg::N_STICKY-1:0] evt_src_i,
    input wire logic dock_detect_i,
    input wire logic undock_req_i,
    input wire logic [N_LIVE-1:0] live_i,
    output logic [pm_regs_pkg::IRQ_LINES-1:0] system_control_interrupt_o,
    output logic irq_o,
    output logic sleep_go_o,
    output logic [pm_regs_pkg::SLEEP_TYPE_W-1:0] sleep_type_o,
    output logic query_valid_o
);

    // ==========================================
    // request carrier and pin synchronisation
    pm_regs_pkg::reg_req_t req;
    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    localparam int NS = pm_regs_pkg::N_STICKY;
    localparam int NRAW = NS + N_LIVE;

    logic [NRAW-1:0] raw_sync;
    logic [NS-1:0] src_sync;
    logic [N_LIVE-1:0] live_sync;
    logic [NS-1:0] src_all;

    pm_sync2 #(
        .W(NRAW)
    ) u_sync (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .d_i({live_i, evt_src_i}),
        .q_o(raw_sync)
    );

    assign src_sync = raw_sync[NS-1:0];
    assign live_sync = raw_sync[NRAW-1:NS];

    logic [1:0] dock_sync;

    pm_sync2 #(
        .W(2)
    ) u_dock_sync (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .d_i({undock_req_i, dock_detect_i}),
        .q_o(dock_sync)
    );

    always_comb begin
        src_all = src_sync;
        src_all[pm_regs_pkg::DOCK_DETECT_BIT] = src_sync[pm_regs_pkg::DOCK_DETECT_BIT] | dock_sync[0];
        src_all[pm_regs_pkg::UNDOCK_REQ_BIT] = src_sync[pm_regs_pkg::UNDOCK_REQ_BIT] | dock_sync[1];
    end

    // ==========================================
    // address decode
    // fixed address decode
    wire sel_ctrl = req.addr == pm_regs_pkg::CTRL_OFS;
    wire sel_sts = req.addr == pm_regs_pkg::STS_OFS;
    wire sel_en = req.addr == pm_regs_pkg::EN_OFS;
    wire sel_live = req.addr == pm_regs_pkg::LIVE_OFS;
    wire sel_query = req.addr == pm_regs_pkg::QUERY_OFS;
    wire sel_irq_sts = req.addr == pm_regs_pkg::IRQ_STS_OFS;
    wire sel_irq_mask = req.addr == pm_regs_pkg::IRQ_MASK_OFS;
    wire sel_evt = req.addr == pm_regs_pkg::EVT_OFS;

    wire wr_ctrl = req.wr & sel_ctrl;
    wire wr_sts = req.wr & sel_sts;
    wire wr_en = req.wr & sel_en;
    wire wr_irq_mask = req.wr & sel_irq_mask;
    wire wr_evt = req.wr & sel_evt;
    wire rd_irq_sts = req.rd & sel_irq_sts;

    // ==========================================
    // control register
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [NS-1:0] en_r;
    logic [pm_regs_pkg::IRQ_STS_W-1:0] irq_mask_r;

    // stored bits read back as written
    // trigger position never stored, so it acts per write
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = req.wdata;
            ctrl_nxt[pm_regs_pkg::SLEEP_TRIGGER_BIT] = 1'b0;
        end
    end

    wire sleep_wr = wr_ctrl & req.wdata[pm_regs_pkg::SLEEP_TRIGGER_BIT];
    wire [pm_regs_pkg::SLEEP_TYPE_W-1:0] type_wr =
        req.wdata[pm_regs_pkg::SLEEP_TYPE_LSB +: pm_regs_pkg::SLEEP_TYPE_W];

    pm_regs_pkg::sleep_cmd_t sleep_cmd;
    assign sleep_cmd = '{sleep_type: type_wr, go: sleep_wr};

    wire [pm_regs_pkg::IRQ_ROUTE_W-1:0] route =
        ctrl_r[pm_regs_pkg::IRQ_ROUTE_LSB +: pm_regs_pkg::IRQ_ROUTE_W];

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_r <= pm_regs_pkg::CTRL_RST;
            en_r <= pm_regs_pkg::EN_RST;
            irq_mask_r <= pm_regs_pkg::IRQ_MASK_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            if (wr_en) begin
                en_r <= req.wdata[NS-1:0];
            end
            if (wr_irq_mask) begin
                irq_mask_r <= req.wdata[pm_regs_pkg::IRQ_STS_W-1:0];
            end
        end
    end

    // ==========================================
    // sticky event status, one cell per bit
    logic [NS-1:0] sticky_r;
    wire [NS-1:0] sticky_nxt;

    generate
        for (genvar i = 0; i < NS; i++) begin : g_sticky
            wire clr = wr_sts & req.wdata[i];
            assign sticky_nxt[i] = src_all[i] | (sticky_r[i] & ~clr);
        end
    endgenerate

    // one process owns the whole vector, cells only build the next value
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sticky_r <= '0;
        end else begin
            sticky_r <= sticky_nxt;
        end
    end

    wire any_evt = |(sticky_r & en_r);

    // ==========================================
    // embedded-controller query value
    logic [7:0] query_r;
    logic [7:0] query_nxt;
    logic query_valid_r;
    logic query_done_r;

    // lowest pending enabled event wins; code is index plus one, zero means none
    always_comb begin
        query_nxt = 8'h00;
        for (int k = NS - 1; k >= 0; k--) begin
            if (sticky_r[k] & en_r[k]) begin
                query_nxt = 8'(k + 1);
            end
        end
    end

    wire query_cmd = wr_evt & req.wdata[pm_regs_pkg::QUERY_CMD_BIT];

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            query_r <= pm_regs_pkg::QUERY_RST;
            query_valid_r <= 1'b0;
            query_done_r <= 1'b0;
        end else begin
            query_done_r <= query_cmd;
            if (query_cmd) begin
                query_r <= query_nxt;
                query_valid_r <= 1'b1;
            end else if (req.rd & sel_query) begin
                query_valid_r <= 1'b0;
            end
        end
    end

    // ==========================================
    // interrupt status, cleared by reading it
    logic [pm_regs_pkg::IRQ_STS_W-1:0] irq_sts_r;
    logic [pm_regs_pkg::IRQ_STS_W-1:0] irq_set;

    always_comb begin
        irq_set = '0;
        irq_set[pm_regs_pkg::IRQ_EVT_BIT] = any_evt;
        irq_set[pm_regs_pkg::IRQ_SLEEP_BIT] = sleep_wr;
        irq_set[pm_regs_pkg::IRQ_QUERY_BIT] = query_done_r;
    end

    // new events win over the read clear
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_sts_r <= '0;
        end else begin
            irq_sts_r <= irq_set | (rd_irq_sts ? '0 : irq_sts_r);
        end
    end

    // ==========================================
    // outputs
    logic [pm_regs_pkg::IRQ_LINES-1:0] sci_nxt;

    // one interrupt, routed to the chosen line
    always_comb begin
        sci_nxt = '0;
        sci_nxt[route] = any_evt;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            system_control_interrupt_o <= '0;
            irq_o <= 1'b0;
            sleep_go_o <= 1'b0;
            sleep_type_o <= '0;
        end else begin
            system_control_interrupt_o <= sci_nxt;
            irq_o <= |(irq_sts_r & irq_mask_r);
            // sleep type sampled with the trigger
            sleep_go_o <= sleep_cmd.go;
            if (sleep_cmd.go) begin
                sleep_type_o <= sleep_cmd.sleep_type;
            end
        end
    end

    assign query_valid_o = query_valid_r;

    // ==========================================
    // read data, one cycle after the strobe
    logic [31:0] rd_mux;

    // live bits read raw synced level
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_ctrl) begin
            rd_mux = ctrl_r;
        end else if (sel_sts) begin
            rd_mux[NS-1:0] = sticky_r;
        end else if (sel_en) begin
            rd_mux[NS-1:0] = en_r;
        end else if (sel_live) begin
            rd_mux[N_LIVE-1:0] = live_sync;
        end else if (sel_query) begin
            rd_mux[7:0] = query_r;
        end else if (sel_irq_sts) begin
            rd_mux[pm_regs_pkg::IRQ_STS_W-1:0] = irq_sts_r;
        end else if (sel_irq_mask) begin
            rd_mux[pm_regs_pkg::IRQ_STS_W-1:0] = irq_mask_r;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= req.rd ? rd_mux : 32'h0000_0000;
        end
    end

endmodule

`default_nettype wire

// ===== hw/pm_sync2.sv
/*
 * Two-flop synchroniser, one per bit.
 * Assumes inputs come from pins or another domain.
 */
`timescale 1ns/1ps
`default_nettype none

module pm_sync2 #(
    parameter int W = 1
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    // ==========================================
    // first stage feeds only the second
    logic [W-1:0] meta_r;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end

endmodule

`default_nettype wire

// ===== pkg/pm_regs_pkg.sv
/*
 * Constants and carrier types for the power-management register bank.
 * Assumes a simple one-cycle register port and a single 125 MHz clock domain.
 */
package pm_regs_pkg;

    // ==========================================
    // register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STS_OFS = 8'h04;
    localparam logic [7:0] EN_OFS = 8'h08;
    localparam logic [7:0] LIVE_OFS = 8'h0c;
    localparam logic [7:0] QUERY_OFS = 8'h10;
    localparam logic [7:0] IRQ_STS_OFS = 8'h14;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
    localparam logic [7:0] EVT_OFS = 8'h1c;

    // ==========================================
    // control register fields
    localparam int SLEEP_TRIGGER_BIT = 13;
    localparam int SLEEP_TYPE_LSB = 10;
    localparam int SLEEP_TYPE_W = 3;
    localparam int IRQ_ROUTE_LSB = 0;
    localparam int IRQ_ROUTE_W = 4;
    localparam int IRQ_LINES = 16;

    // ==========================================
    // sticky event sources in the status register
    localparam int N_STICKY = 8;
    localparam int DOCK_DETECT_BIT = 0;
    localparam int UNDOCK_REQ_BIT = 1;

    // interrupt status bits
    localparam int IRQ_STS_W = 3;
    localparam int IRQ_EVT_BIT = 0;
    localparam int IRQ_SLEEP_BIT = 1;
    localparam int IRQ_QUERY_BIT = 2;

    // event register: write-only query command bit
    localparam int QUERY_CMD_BIT = 0;

    // ==========================================
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [N_STICKY-1:0] EN_RST = 8'h00;
    localparam logic [IRQ_STS_W-1:0] IRQ_MASK_RST = 3'h0;
    localparam logic [7:0] QUERY_RST = 8'h00;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [SLEEP_TYPE_W-1:0] sleep_type;
        logic go;
    } sleep_cmd_t;

endpackage

// ===== testbench/pm_reg_bank_properties.sv
/* port properties of the power-management register bank.
   assumes it is bound onto pm_reg_bank, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module pm_reg_bank_checker #(
    parameter int N_LIVE = 8
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [N_LIVE-1:0] live_i,
    input wire logic [pm_regs_pkg::IRQ_LINES-1:0] system_control_interrupt_o,
    input wire logic sleep_go_o,
    input wire logic [pm_regs_pkg::SLEEP_TYPE_W-1:0] sleep_type_o,
    input wire logic query_valid_o
);
    wire ctrl_wr = wr_i && addr_i == pm_regs_pkg::CTRL_OFS;
    wire go_wr = ctrl_wr && wdata_i[pm_regs_pkg::SLEEP_TRIGGER_BIT];
    wire [2:0] wtype = wdata_i[pm_regs_pkg::SLEEP_TYPE_LSB +: pm_regs_pkg::SLEEP_TYPE_W];
    wire q_cmd = wr_i && addr_i == pm_regs_pkg::EVT_OFS && wdata_i[pm_regs_pkg::QUERY_CMD_BIT];
    // live value must be steady across the two sync flops
    wire live_rd = rd_i && addr_i == pm_regs_pkg::LIVE_OFS;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // ==========================================
    // assertions and cover points
    a_unmapped_zero: assert property (rd_i && addr_i >= 8'h20 |=> rdata_o == 32'h0)
        else $error("unmapped read returned nonzero");
    a_trigger_fires: assert property (go_wr |=> sleep_go_o && sleep_type_o == $past(wtype))
        else $error("sleep trigger write gave no pulse");
    a_no_stray_go: assert property (!go_wr |=> !sleep_go_o)
        else $error("sleep pulse without trigger write");
    a_trigger_reads0: assert property (rd_i && addr_i == pm_regs_pkg::CTRL_OFS |=> !rdata_o[13])
        else $error("trigger bit read back high");
    a_live_direct: assert property (live_rd && live_i == $past(live_i) && live_i == $past(live_i, 2)
        && live_i == $past(live_i, 3) |=> rdata_o[N_LIVE-1:0] == $past(live_i))
        else $error("live status read mismatch");
    a_sci_one_line: assert property ($onehot0(system_control_interrupt_o))
        else $error("interrupt on several lines");
    a_query_set: assert property (q_cmd |=> query_valid_o)
        else $error("query command not flagged");
    a_query_clear: assert property (rd_i && addr_i == pm_regs_pkg::QUERY_OFS |=> !query_valid_o)
        else $error("query flag survived read");
    a_type_hold: assert property (!go_wr |=> $stable(sleep_type_o))
        else $error("sleep type moved without trigger");
    c_sleep: cover property (go_wr ##1 sleep_go_o);
    c_query: cover property (q_cmd ##1 query_valid_o);
    c_sci: cover property (system_control_interrupt_o != 16'h0);
endmodule
`default_nettype wire

// ===== testbench/pm_reg_bank_tb_top.sv
/* self-checking bench for the power-management register bank.
   assumes pm_regs_pkg, pm_reg_bank and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module pm_reg_bank_tb_top;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] evt_src_i = 8'h00;
    logic dock_detect_i = 1'b0;
    logic undock_req_i = 1'b0;
    logic [7:0] live_i = 8'h00;
    logic [31:0] rdata_o;
    logic [15:0] system_control_interrupt_o;
    logic irq_o, sleep_go_o, query_valid_o;
    logic [2:0] sleep_type_o;
    int num_errors = 0;
    int compares = 0;
    always #4 mclk_i = ~mclk_i;
    pm_reg_bank #(.N_LIVE(8)) u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .evt_src_i(evt_src_i),
        .dock_detect_i(dock_detect_i), .undock_req_i(undock_req_i), .live_i(live_i),
        .system_control_interrupt_o(system_control_interrupt_o), .irq_o(irq_o),
        .sleep_go_o(sleep_go_o), .sleep_type_o(sleep_type_o), .query_valid_o(query_valid_o));
    // ==========================================
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask
    task automatic finish_test;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ==========================================
    // sequence
    initial begin
        tick(10);
        rst_b_i <= 1'b1;
        rdc(pm_regs_pkg::CTRL_OFS, 32'h0);
        rdc(pm_regs_pkg::EN_OFS, 32'h0);
        rdc(pm_regs_pkg::QUERY_OFS, 32'h0);
        // type 5, route line 3, trigger set
        wr(pm_regs_pkg::CTRL_OFS, 32'h0000_3403);
        check(sleep_go_o, 32'h1);
        check(sleep_type_o, 32'h5);
        rdc(pm_regs_pkg::CTRL_OFS, 32'h0000_1403);
        check(sleep_go_o, 32'h0);
        wr(pm_regs_pkg::CTRL_OFS, 32'h0000_0803);
        check(sleep_go_o, 32'h0);
        check(sleep_type_o, 32'h5);
        rdc(pm_regs_pkg::CTRL_OFS, 32'h0000_0803);
        wr(pm_regs_pkg::EN_OFS, 32'h7);
        rdc(pm_regs_pkg::EN_OFS, 32'h7);
        @(posedge mclk_i) live_i <= 8'ha5;
        tick(3);
        rdc(pm_regs_pkg::LIVE_OFS, 32'ha5);
        @(posedge mclk_i) live_i <= 8'h5a;
        tick(3);
        rdc(pm_regs_pkg::LIVE_OFS, 32'h5a);
        // short pulse on source 2, must be latched
        @(posedge mclk_i) evt_src_i <= 8'h04;
        tick(5);
        evt_src_i <= 8'h00;
        tick(4);
        rdc(pm_regs_pkg::STS_OFS, 32'h4);
        check(system_control_interrupt_o, 32'h8);
        wr(pm_regs_pkg::STS_OFS, 32'h0);
        rdc(pm_regs_pkg::STS_OFS, 32'h4);
        wr(pm_regs_pkg::STS_OFS, 32'h4);
        rdc(pm_regs_pkg::STS_OFS, 32'h0);
        check(system_control_interrupt_o, 32'h0);
        @(posedge mclk_i) dock_detect_i <= 1'b1;
        tick(5);
        dock_detect_i <= 1'b0;
        tick(4);
        rdc(pm_regs_pkg::STS_OFS, 32'h1);
        check(irq_o, 32'h0);
        wr(pm_regs_pkg::IRQ_MASK_OFS, 32'h1);
        tick(2);
        check(irq_o, 32'h1);
        wr(pm_regs_pkg::STS_OFS, 32'h1);
        tick(2);
        rdc(pm_regs_pkg::IRQ_STS_OFS, 32'h3);
        rdc(pm_regs_pkg::IRQ_STS_OFS, 32'h0);
        check(irq_o, 32'h0);
        // clear while the source is still high
        @(posedge mclk_i) undock_req_i <= 1'b1;
        tick(5);
        wr(pm_regs_pkg::STS_OFS, 32'h2);
        rdc(pm_regs_pkg::STS_OFS, 32'h2);
        @(posedge mclk_i) undock_req_i <= 1'b0;
        tick(4);
        wr(pm_regs_pkg::STS_OFS, 32'h2);
        rdc(pm_regs_pkg::STS_OFS, 32'h0);
        @(posedge mclk_i) evt_src_i <= 8'h04;
        tick(5);
        evt_src_i <= 8'h00;
        tick(4);
        wr(pm_regs_pkg::EVT_OFS, 32'h1);
        check(query_valid_o, 32'h1);
        rdc(pm_regs_pkg::QUERY_OFS, 32'h3);
        check(query_valid_o, 32'h0);
        rdc(pm_regs_pkg::IRQ_STS_OFS, 32'h5);
        rdc(8'h20, 32'h0);
        finish_test();
    end
    // hang guard
    initial begin
        tick(5000);
        num_errors++;
        finish_test();
    end
endmodule
bind pm_reg_bank pm_reg_bank_checker #(.N_LIVE(N_LIVE)) u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .live_i(live_i),
    .system_control_interrupt_o(system_control_interrupt_o), .sleep_go_o(sleep_go_o),
    .sleep_type_o(sleep_type_o), .query_valid_o(query_valid_o));
`default_nettype wire
